// ==== common/fcp_pkg.sv ====
// shared constants, opcodes and carrier types of the flash command host
`default_nettype none
package fcp_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   // command codes; unused upper address bits go out as zero
   localparam logic [ADDR_W-1:0] UNLK_ADDR1 = 19'h00555;
   localparam logic [ADDR_W-1:0] UNLK_ADDR2 = 19'h002aa;
   localparam logic [7:0] UNLK_DATA1 = 8'haa;
   localparam logic [7:0] UNLK_DATA2 = 8'h55;
   localparam logic [7:0] CMD_RESET = 8'hf0;
   localparam logic [7:0] CMD_AUTOSEL = 8'h90;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_BYPASS = 8'h20;
   localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   // status bit positions on the byte lines
   localparam int POLL_BIT = 7;
   localparam int TFAIL_BIT = 5;
   // timings and derived cycle counts
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_WE_LOW_NS = 50;
   localparam int T_RD_ACC_NS = 100;
   localparam int T_SECT_WIN_US = 50;
   localparam int T_SUSPEND_US = 20;
   localparam logic [7:0] WE_LOW_CYC = 8'((T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] RD_ACC_CYC = 8'((T_RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] SECT_WIN_CYC = 12'((T_SECT_WIN_US * 1000) / CLK_PERIOD_NS);
   localparam logic [11:0] SUSPEND_CYC =
      12'((T_SUSPEND_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // host register offsets and status fields
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_RESULT = 8'h10;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_REFUSED = 3;
   localparam int ST_BYPASS = 4;
   localparam int ST_SUSPENDED = 5;
   localparam int ST_ERASING = 6;
   localparam int ST_WINDOW = 7;
   // host operation codes written to the command register
   localparam logic [3:0] OP_READ = 4'h0;
   localparam logic [3:0] OP_RESET = 4'h1;
   localparam logic [3:0] OP_AUTOSEL = 4'h2;
   localparam logic [3:0] OP_PROGRAM = 4'h3;
   localparam logic [3:0] OP_BYP_ENTER = 4'h4;
   localparam logic [3:0] OP_BYP_PROG = 4'h5;
   localparam logic [3:0] OP_BYP_EXIT = 4'h6;
   localparam logic [3:0] OP_CHIP_ERASE = 4'h7;
   localparam logic [3:0] OP_SECT_ERASE = 4'h8;
   localparam logic [3:0] OP_SECT_ADD = 4'h9;
   localparam logic [3:0] OP_ERASE_POLL = 4'ha;
   localparam logic [3:0] OP_SUSPEND = 4'hb;
   localparam logic [3:0] OP_RESUME = 4'hc;
   // one bus cycle toward the flash
   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fcp_cyc_s;
   typedef enum logic [1:0] {PD_MORE, PD_PASS, PD_RECHECK, PD_FAIL} fcp_poll_e;
endpackage : fcp_pkg
`default_nettype wire

// ==== verilog/fcp_bus_cycle.sv ====
// single read or write cycle generator on the flash parallel pins
`default_nettype none
module fcp_bus_cycle (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_req,
   input wire fcp_pkg::fcp_cyc_s i_cyc,
   output logic o_idle,
   output logic o_done,
   output logic [fcp_pkg::DATA_W-1:0] o_rdata,
   output logic [fcp_pkg::ADDR_W-1:0] o_addr,
   output logic [fcp_pkg::DATA_W-1:0] o_dq_out,
   output logic o_dq_oe,
   input wire logic [fcp_pkg::DATA_W-1:0] i_dq_in,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n
);
   import fcp_pkg::*;
   typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} fcp_bus_e;
   fcp_bus_e state;
   logic [7:0] cnt;
   logic wr;

   assign o_idle = (state == B_IDLE);

   // address and data hold through the strobe for either latch edge
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= B_IDLE;
         cnt <= 8'h00;
         wr <= 1'b0;
         o_done <= 1'b0;
         o_rdata <= 8'h00;
         o_addr <= '0;
         o_dq_out <= 8'h00;
         o_dq_oe <= 1'b0;
         o_ce_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_we_n <= 1'b1;
      end else begin
         o_done <= 1'b0;
         case (state)
            B_IDLE: if (i_req) begin
               o_addr <= i_cyc.addr;
               o_dq_out <= i_cyc.data;
               o_dq_oe <= i_cyc.wr;
               wr <= i_cyc.wr;
               o_ce_n <= 1'b0;
               state <= B_SETUP;
            end
            B_SETUP: begin
               o_we_n <= ~wr;
               o_oe_n <= wr;
               cnt <= wr ? WE_LOW_CYC - 8'h01 : RD_ACC_CYC - 8'h01;
               state <= B_STROBE;
            end
            B_STROBE: if (cnt == 8'h00) begin
               o_we_n <= 1'b1; // [RQ14]
               o_oe_n <= 1'b1;
               if (!wr) o_rdata <= i_dq_in;
               state <= B_HOLD;
            end else begin
               cnt <= cnt - 8'h01;
            end
            // data held one cycle past strobe rise
            B_HOLD: begin
               o_ce_n <= 1'b1;
               o_dq_oe <= 1'b0;
               o_done <= 1'b1;
               state <= B_IDLE;
            end
            default: state <= B_IDLE;
         endcase
      end
   end
endmodule : fcp_bus_cycle
`default_nettype wire

// ==== verilog/fcp_poll_eval.sv ====
// decision on one complement-polling status read
`default_nettype none
module fcp_poll_eval (
   input wire logic [fcp_pkg::DATA_W-1:0] i_rbyte,
   input wire logic i_expect,
   input wire logic i_recheck,
   input wire logic i_limit,
   output fcp_pkg::fcp_poll_e o_decision
);
   import fcp_pkg::*;
   wire poll_true = (i_rbyte[POLL_BIT] == i_expect); // [RQ16] [RQ19]
   wire tfail = i_rbyte[TFAIL_BIT];

   // true data wins over the fail bit; both may flip together
   assign o_decision = poll_true ? PD_PASS : // [RQ22]
                       (tfail && i_recheck) ? PD_FAIL :
                       tfail ? PD_RECHECK :
                       i_limit ? PD_FAIL : PD_MORE;
endmodule : fcp_poll_eval
`default_nettype wire

// ==== verilog/fcp_flash_host.sv ====
// host controller issuing flash command sequences and complement polling
// How it works
// [RQ1] every unlocked command opens with AA/555, 55/2AA
// [RQ2] plain reads need no unlock, return array data
// [RQ3] F0 write returns to array read, ends ID
// [RQ4] ID read after 90: maker, part, protection
// [RQ5] protection read is 00h unprotected, else nonzero
// [RQ6] program is unlock pair, A0, then data
// [RQ7] unlock pair plus 20 enters bypass mode
// [RQ8] bypass program is A0 then data byte
// [RQ9] bypass exit is 90 then 00, only exit
// [RQ10] erase: unlock, 80, unlock, then 10 or 30
// [RQ11] suspend B0 only honoured during sector erase
// [RQ12] resume 30 only accepted while erase suspended
// [RQ13] suspended: reads, programs, ID entry still allowed
// [RQ14] address latched late falling, data early rising
// [RQ15] polling valid from final write strobe rise
// [RQ16] program polls complement bit, then true value
// [RQ17] program status reads use the programmed address
// [RQ18] protected program target polls briefly, then reverts
// [RQ19] erase poll reads 0, then 1 when done/suspended
// [RQ20] erase status reads use an erasing sector address
// [RQ21] all-protected erase polls briefly, then reverts
// [RQ22] accept data only on later read; recheck fail
// [RQ23] sector additions within 50 us window, restarting it
// [RQ24] suspend settles within 20 us, immediate in window
// [RQ25] broken command pattern abandons sequence to read
`default_nettype none
module fcp_flash_host #(
   parameter logic [15:0] POLL_MAX = 16'hffff
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   output logic [fcp_pkg::ADDR_W-1:0] o_flash_addr,
   output logic [fcp_pkg::DATA_W-1:0] o_flash_dq_out,
   output logic o_flash_dq_oe,
   input wire logic [fcp_pkg::DATA_W-1:0] i_flash_dq_in,
   output logic o_flash_ce_n,
   output logic o_flash_oe_n,
   output logic o_flash_we_n
);
   import fcp_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE, S_SEQ, S_SEQ_W, S_POLL, S_POLL_W, S_FINAL, S_FINAL_W, S_ABORT, S_ABORT_W, S_HOLD
   } fcp_state_e;

   fcp_state_e state;
   logic [3:0] op;
   logic [2:0] step;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] data_reg;
   logic [DATA_W-1:0] result;
   logic [ADDR_W-1:0] erase_addr;
   logic [ADDR_W-1:0] poll_addr;
   logic poll_expect;
   logic poll_erase;
   logic recheck;
   logic [15:0] poll_cnt;
   logic done, fail, refused;
   logic bypass, suspended, erasing, sect_mode, window_open;
   logic [11:0] win_cnt;
   logic [11:0] hold_cnt;

   // write cycle helper
   function automatic fcp_cyc_s wcyc(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      fcp_cyc_s c;
      c.wr = 1'b1;
      c.addr = a;
      c.data = d;
      return c;
   endfunction : wcyc

   // read cycle helper
   function automatic fcp_cyc_s rcyc(input logic [ADDR_W-1:0] a);
      fcp_cyc_s c;
      c.wr = 1'b0;
      c.addr = a;
      c.data = 8'h00;
      return c;
   endfunction : rcyc

   // number of bus cycles in each operation's fixed sequence
   function automatic logic [2:0] seq_len(input logic [3:0] o);
      case (o)
         OP_AUTOSEL: return 3'h5;
         OP_PROGRAM: return 3'h4;
         OP_BYP_ENTER: return 3'h3;
         OP_BYP_PROG, OP_BYP_EXIT: return 3'h2;
         OP_CHIP_ERASE, OP_SECT_ERASE: return 3'h6;
         OP_ERASE_POLL: return 3'h0;
         default: return 3'h1;
      endcase
   endfunction : seq_len

   // bus cycle for a given step of an operation
   function automatic fcp_cyc_s seq_cycle(input logic [3:0] o, input logic [2:0] s,
                                          input logic [ADDR_W-1:0] a, input logic [7:0] d);
      fcp_cyc_s unl;
      unl = (s == 3'h0 || s == 3'h3) ? wcyc(UNLK_ADDR1, UNLK_DATA1) // [RQ1]
                                     : wcyc(UNLK_ADDR2, UNLK_DATA2);
      case (o)
         OP_READ: return rcyc(a); // [RQ2]
         OP_RESET: return wcyc(a, CMD_RESET); // [RQ3]
         // fourth cycle reads, fifth leaves ID mode
         OP_AUTOSEL: case (s)
            3'h2: return wcyc(UNLK_ADDR1, CMD_AUTOSEL);
            3'h3: return rcyc(a); // [RQ4] [RQ5] [RQ13]
            3'h4: return wcyc(a, CMD_RESET); // [RQ3]
            default: return unl;
         endcase
         OP_PROGRAM: case (s)
            3'h2: return wcyc(UNLK_ADDR1, CMD_PROGRAM);
            3'h3: return wcyc(a, d); // [RQ6]
            default: return unl;
         endcase
         OP_BYP_ENTER: return (s == 3'h2) ? wcyc(UNLK_ADDR1, CMD_BYPASS) : unl; // [RQ7]
         OP_BYP_PROG: return (s == 3'h0) ? wcyc(a, CMD_PROGRAM) : wcyc(a, d); // [RQ8]
         OP_BYP_EXIT: return (s == 3'h0) ? wcyc(a, CMD_AUTOSEL) : wcyc(a, CMD_BYP_EXIT2); // [RQ9]
         OP_CHIP_ERASE, OP_SECT_ERASE: case (s)
            3'h2: return wcyc(UNLK_ADDR1, CMD_ERASE_SETUP);
            3'h5: return (o == OP_CHIP_ERASE) ? wcyc(UNLK_ADDR1, CMD_CHIP_ERASE) // [RQ10]
                                              : wcyc(a, CMD_SECT_ERASE);
            default: return unl;
         endcase
         OP_SECT_ADD: return wcyc(a, CMD_SECT_ERASE); // [RQ23]
         OP_SUSPEND: return wcyc(a, CMD_SUSPEND);
         default: return wcyc(a, CMD_RESUME);
      endcase
   endfunction : seq_cycle

   // illegal orders are refused, so no sequence is ever broken
   function automatic logic op_legal(input logic [3:0] o, input logic byp, input logic susp,
                                     input logic ers, input logic sect, input logic win);
      if (byp) return o == OP_READ || o == OP_BYP_PROG || o == OP_BYP_EXIT; // [RQ9] [RQ25]
      if (susp) return o == OP_READ || o == OP_PROGRAM || o == OP_AUTOSEL || // [RQ13]
                       o == OP_RESUME || o == OP_ERASE_POLL; // [RQ12]
      if (ers) return o == OP_READ || o == OP_ERASE_POLL || o == OP_RESET ||
                      (o == OP_SUSPEND && sect) || (o == OP_SECT_ADD && win); // [RQ11] [RQ23]
      return o <= OP_SECT_ERASE && o != OP_BYP_PROG && o != OP_BYP_EXIT; // [RQ8]
   endfunction : op_legal

   // register port decode
   wire cmd_wr = i_reg_wr && (i_reg_addr == REG_CMD);
   wire [3:0] new_op = i_reg_wdata[3:0];
   wire accept = cmd_wr && (state == S_IDLE) &&
                 op_legal(new_op, bypass, suspended, erasing, sect_mode, window_open);
   wire reject = cmd_wr && !accept;
   wire [7:0] status = {window_open, erasing, suspended, bypass, refused, fail, done,
                        state != S_IDLE};
   wire [31:0] rd_mux = (i_reg_addr == REG_ADDR) ? {13'h0000, addr_reg} :
                        (i_reg_addr == REG_DATA) ? {24'h000000, data_reg} :
                        (i_reg_addr == REG_STATUS) ? {24'h000000, status} :
                        (i_reg_addr == REG_RESULT) ? {24'h000000, result} : 32'h00000000;

   // bus cycle selection and handshake
   wire bus_idle;
   wire bus_done;
   wire [DATA_W-1:0] bus_rdata;
   wire issue = (state == S_SEQ) || (state == S_POLL) || (state == S_FINAL) ||
                (state == S_ABORT);
   wire bus_req = issue && bus_idle;
   wire fcp_cyc_s seq_cyc = seq_cycle(op, step, addr_reg, data_reg);
   wire fcp_cyc_s bus_cyc = (state == S_SEQ) ? seq_cyc :
                            (state == S_ABORT) ? wcyc(poll_addr, CMD_RESET) : // [RQ3]
                            rcyc(poll_addr); // [RQ17] [RQ20]
   wire last_step = (step == seq_len(op) - 3'h1);
   wire is_prog = (op == OP_PROGRAM) || (op == OP_BYP_PROG);
   wire is_erase_start = (op == OP_CHIP_ERASE) || (op == OP_SECT_ERASE);
   wire seq_end = (state == S_SEQ_W) && bus_done && last_step;
   wire win_restart = seq_end && ((op == OP_SECT_ERASE) || (op == OP_SECT_ADD)); // [RQ23]
   fcp_poll_e decision;
   wire poll_limit = (poll_cnt == POLL_MAX);

   fcp_bus_cycle u_bus (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_req(bus_req),
      .i_cyc(bus_cyc),
      .o_idle(bus_idle),
      .o_done(bus_done),
      .o_rdata(bus_rdata),
      .o_addr(o_flash_addr),
      .o_dq_out(o_flash_dq_out),
      .o_dq_oe(o_flash_dq_oe),
      .i_dq_in(i_flash_dq_in),
      .o_ce_n(o_flash_ce_n),
      .o_oe_n(o_flash_oe_n),
      .o_we_n(o_flash_we_n)
   );

   fcp_poll_eval u_poll (
      .i_rbyte(bus_rdata),
      .i_expect(poll_expect),
      .i_recheck(recheck),
      .i_limit(poll_limit),
      .o_decision(decision)
   );

   // software registers; a refusal beats a clear in one cycle
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         addr_reg <= '0;
         data_reg <= 8'h00;
         refused <= 1'b0;
         o_reg_rdata <= 32'h00000000;
      end else begin
         if (i_reg_wr && i_reg_addr == REG_ADDR) addr_reg <= i_reg_wdata[ADDR_W-1:0];
         if (i_reg_wr && i_reg_addr == REG_DATA) data_reg <= i_reg_wdata[DATA_W-1:0];
         refused <= reject | (refused & ~accept);
         o_reg_rdata <= i_reg_rd ? rd_mux : 32'h00000000;
      end
   end

   // sector window, restarted by each sector write
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         window_open <= 1'b0;
         win_cnt <= 12'h000;
      end else if (win_restart) begin
         window_open <= 1'b1; // [RQ23]
         win_cnt <= SECT_WIN_CYC - 12'h001;
      end else if (suspended || state == S_ABORT_W) begin
         window_open <= 1'b0;
      end else if (window_open) begin
         if (win_cnt == 12'h000) window_open <= 1'b0;
         win_cnt <= win_cnt - 12'h001;
      end
   end

   // sequencer and poll loop
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= S_IDLE;
         op <= OP_READ;
         step <= 3'h0;
         result <= 8'h00;
         erase_addr <= '0;
         poll_addr <= '0;
         poll_expect <= 1'b0;
         poll_erase <= 1'b0;
         recheck <= 1'b0;
         poll_cnt <= 16'h0000;
         hold_cnt <= 12'h000;
         done <= 1'b0;
         fail <= 1'b0;
         bypass <= 1'b0;
         suspended <= 1'b0;
         erasing <= 1'b0;
         sect_mode <= 1'b0;
      end else begin
         case (state)
            S_IDLE: if (accept) begin
               op <= new_op;
               step <= 3'h0;
               done <= 1'b0;
               fail <= 1'b0;
               recheck <= 1'b0;
               poll_cnt <= 16'h0000;
               poll_addr <= erase_addr;
               poll_expect <= 1'b1;
               poll_erase <= 1'b1;
               state <= (new_op == OP_ERASE_POLL) ? S_POLL : S_SEQ;
            end
            S_SEQ: if (bus_idle) state <= S_SEQ_W;
            S_SEQ_W: if (bus_done) begin
               if (!seq_cyc.wr) result <= bus_rdata;
               step <= step + 3'h1;
               state <= S_SEQ;
               if (last_step) begin
                  state <= S_IDLE;
                  done <= 1'b1;
                  // polling follows the final write strobe
                  if (is_prog || op == OP_CHIP_ERASE) begin
                     poll_addr <= addr_reg; // [RQ17] [RQ20]
                     poll_expect <= is_prog ? data_reg[POLL_BIT] : 1'b1; // [RQ15]
                     poll_erase <= !is_prog;
                     done <= 1'b0;
                     state <= S_POLL;
                  end
                  if (is_erase_start) begin
                     erasing <= 1'b1;
                     sect_mode <= (op == OP_SECT_ERASE);
                     erase_addr <= addr_reg;
                  end
                  if (op == OP_BYP_ENTER) bypass <= 1'b1; // [RQ7]
                  if (op == OP_BYP_EXIT) bypass <= 1'b0; // [RQ9]
                  if (op == OP_RESET) begin
                     erasing <= 1'b0;
                     sect_mode <= 1'b0;
                  end
                  if (op == OP_RESUME) suspended <= 1'b0; // [RQ12]
                  // suspend inside the window takes effect at once
                  if (op == OP_SUSPEND) begin
                     done <= window_open;
                     suspended <= window_open;
                     hold_cnt <= SUSPEND_CYC - 12'h001;
                     state <= window_open ? S_IDLE : S_HOLD; // [RQ24]
                  end
               end
            end
            S_HOLD: if (hold_cnt == 12'h000) begin
               suspended <= 1'b1; // [RQ24]
               done <= 1'b1;
               state <= S_IDLE;
            end else begin
               hold_cnt <= hold_cnt - 12'h001;
            end
            S_POLL: if (bus_idle) state <= S_POLL_W;
            // protected targets revert to array data, which reads as true data
            S_POLL_W: if (bus_done) begin
               poll_cnt <= poll_cnt + 16'h0001;
               case (decision)
                  PD_PASS: state <= S_FINAL; // [RQ18] [RQ21] [RQ22]
                  PD_RECHECK: begin
                     recheck <= 1'b1; // [RQ22]
                     state <= S_POLL;
                  end
                  PD_FAIL: state <= S_ABORT;
                  default: state <= S_POLL;
               endcase
            end
            S_FINAL: if (bus_idle) state <= S_FINAL_W;
            // the read after true data is the one that carries a valid byte
            S_FINAL_W: if (bus_done) begin
               result <= bus_rdata; // [RQ22]
               done <= 1'b1;
               if (poll_erase && !suspended) begin
                  erasing <= 1'b0; // [RQ19]
                  sect_mode <= 1'b0;
               end
               state <= S_IDLE;
            end
            S_ABORT: if (bus_idle) state <= S_ABORT_W;
            S_ABORT_W: if (bus_done) begin
               fail <= 1'b1; // [RQ3]
               done <= 1'b1;
               if (!suspended) begin
                  erasing <= 1'b0;
                  sect_mode <= 1'b0;
               end
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule : fcp_flash_host
`default_nettype wire

// ==== verilog/fcp_flash_host_unused_placeholder_none.sv ====
// reserved, holds no design unit
`default_nettype none
`default_nettype wire

// ==== sim/fcp_flash_host_properties.sv ====
// concurrent checks on the flash host pins
`default_nettype none
module fcp_flash_host_properties #(
   parameter logic [15:0] POLL_MAX = 16'hffff
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire logic [fcp_pkg::ADDR_W-1:0] o_flash_addr,
   input wire logic [fcp_pkg::DATA_W-1:0] o_flash_dq_out,
   input wire logic o_flash_dq_oe,
   input wire logic o_flash_ce_n,
   input wire logic o_flash_oe_n,
   input wire logic o_flash_we_n
);
   import fcp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   we_pulse_a: assert property ($fell(o_flash_we_n) |=> !o_flash_we_n ##1 o_flash_we_n)
      else $error("write strobe not two cycles low");
   we_select_a: assert property (!o_flash_we_n |-> !o_flash_ce_n && o_flash_oe_n)
      else $error("write strobe without chip select");
   we_data_a: assert property (!o_flash_we_n |-> o_flash_dq_oe && $stable(o_flash_dq_out))
      else $error("byte lines moved under write strobe");
   wr_release_a: assert property ($rose(o_flash_we_n) |-> o_flash_dq_oe ##1 !o_flash_dq_oe)
      else $error("drive not held past strobe rise");
   oe_pulse_a: assert property ($fell(o_flash_oe_n) |=> !o_flash_oe_n [*3] ##1 o_flash_oe_n)
      else $error("read strobe not four cycles low");
   read_float_a: assert property (!o_flash_oe_n |-> !o_flash_dq_oe && !o_flash_ce_n)
      else $error("host drives during read");
   ce_idle_a: assert property (o_flash_ce_n |-> o_flash_oe_n && o_flash_we_n)
      else $error("strobe while deselected");
   addr_hold_a: assert property (!o_flash_ce_n && !$past(o_flash_ce_n) |-> $stable(o_flash_addr))
      else $error("address changed inside a cycle");
   rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h00000000)
      else $error("read data outside its slot");
   cover property ($fell(o_flash_we_n));
   cover property ($fell(o_flash_oe_n));
   cover property (i_reg_rd && i_reg_addr == REG_STATUS);
endmodule : fcp_flash_host_properties
bind fcp_flash_host fcp_flash_host_properties #(.POLL_MAX(POLL_MAX)) i_props (.*);
`default_nettype wire

// ==== sim/fcp_flash_model.sv ====
// behavioural flash device decoding command cycles and complement polling
`default_nettype none
module fcp_flash_model #(
   parameter logic [7:0] MAKER = 8'h3c, // arbitrary value
   parameter logic [7:0] PART = 8'hc3 // arbitrary value
) (
   input wire logic [18:0] i_addr,
   input wire logic [7:0] i_dq,
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   output logic [7:0] o_dq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   logic [7:0] pb = 8'h00, last = 8'h00, rd;
   logic [18:0] la = 19'h00000;
   int st = 0, busy = 0;
   logic id = 0, prg = 0, byp = 0, ex = 0, er = 0;
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
   // status outranks array data while busy; no sector is protected
   assign rd = busy > 0 ? {~pb[7], 7'h00} :
      !id ? mem[i_addr[7:0]] : i_addr[1:0] == 2'h0 ? MAKER :
      i_addr[1:0] == 2'h1 ? PART : 8'h00;
   // released lines show the inverse of the last byte
   assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~last;
   always @(posedge i_oe_n) begin
      last = rd;
      if (busy > 0) busy--;
   end
   always @(negedge i_we_n) la = i_addr;
   // command decoder, data taken at the strobe rise
   always @(posedge i_we_n) begin
      if (prg) begin
         mem[la[7:0]] = i_dq;
         pb = i_dq;
         busy = 3;
         prg = 0;
      end else if (byp) begin
         prg = i_dq == 8'ha0;
         byp = !(ex && i_dq == 8'h00);
         ex = i_dq == 8'h90;
      end else if (i_dq == 8'hf0) begin
         st = 0;
         id = 0;
      end else if (st == 0 && la[10:0] == 11'h555 && i_dq == 8'haa) st = 1;
      else if (st == 1 && la[10:0] == 11'h2aa && i_dq == 8'h55) st = 2;
      else if (st == 2 && la[10:0] == 11'h555) begin
         id = i_dq == 8'h90;
         prg = i_dq == 8'ha0;
         byp = i_dq == 8'h20;
         if (er && i_dq == 8'h10) begin
            for (int i = 0; i < 256; i++) mem[i] = 8'hff;
            pb = 8'hff;
            busy = 3;
         end
         er = i_dq == 8'h80;
         st = 0;
      end else st = 0;
   end
endmodule : fcp_flash_model
`default_nettype wire

// ==== sim/testbench.sv ====
// register-level tests of the flash host against the device model
`default_nettype none
module testbench;
   import fcp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MK = 8'h3c; // arbitrary value
   localparam logic [7:0] PT = 8'hc3; // arbitrary value
   logic i_clk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic [7:0] i_reg_addr = 8'h00, fdo, mdq, bus;
   logic [31:0] i_reg_wdata = 32'h00000000, o_reg_rdata, rv;
   logic [18:0] fa;
   logic oe, ce_n, oe_n, we_n;
   logic [7:0] idv [3] = '{MK, PT, 8'h00};
   int err_total = 0, check_count = 0;
   assign bus = oe ? fdo : mdq; // drive owner
   initial forever #12.5 i_clk = ~i_clk;
   fcp_flash_host #(.POLL_MAX(16'h0032)) i_fcp_flash_host (.i_clk, .i_sys_rst, .i_reg_addr,
      .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_flash_addr(fa), .o_flash_dq_out(fdo),
      .o_flash_dq_oe(oe), .i_flash_dq_in(bus), .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n),
      .o_flash_we_n(we_n));
   fcp_flash_model #(.MAKER(MK), .PART(PT)) i_fcp_flash_model (.i_addr(fa), .i_dq(bus),
      .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .o_dq(mdq));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
      #1;
   endtask : wr
   // data taken just after the slot edge
   task automatic rd(input logic [7:0] a);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      #1 rv = o_reg_rdata;
   endtask : rd
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // launch an order, then poll until idle
   task automatic op(input logic [3:0] c, input logic [18:0] a, input logic [7:0] d);
      wr(REG_ADDR, {13'h0000, a});
      wr(REG_DATA, {24'h000000, d});
      wr(REG_CMD, {28'h0000000, c});
      repeat (400) begin
         rd(REG_STATUS);
         if (rv[ST_BUSY] === 1'b0) break;
      end
   endtask : op
   task automatic res(input string n, input logic [7:0] e);
      rd(REG_RESULT);
      chk(n, {24'h000000, e}, rv);
   endtask : res
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      rd(REG_STATUS);
      chk("status", 32'h00000000, rv);
      rd(8'h20);
      chk("unmapped", 32'h00000000, rv);
      op(OP_READ, 19'h00012, 8'h00);
      res("array read", 8'hb7);
      op(OP_PROGRAM, 19'h00033, 8'h5a);
      res("program", 8'h5a);
      for (int i = 0; i < 3; i++) begin
         op(OP_AUTOSEL, 19'(i), 8'h00);
         res("ident", idv[i]);
      end
      op(OP_READ, 19'h00033, 8'h00);
      res("after ident", 8'h5a);
      op(OP_BYP_ENTER, 19'h00000, 8'h00);
      chk("bypass", 32'h1, 32'(rv[ST_BYPASS]));
      op(OP_PROGRAM, 19'h00033, 8'h11);
      chk("refused", 32'h1, 32'(rv[ST_REFUSED]));
      op(OP_BYP_PROG, 19'h00044, 8'h96);
      res("bypass program", 8'h96);
      op(OP_BYP_EXIT, 19'h00000, 8'h00);
      chk("bypass exit", 32'h0, 32'(rv[ST_BYPASS]));
      op(OP_CHIP_ERASE, 19'h00010, 8'h00);
      res("erase", 8'hff);
      op(OP_READ, 19'h00044, 8'h00);
      res("erased", 8'hff);
      wrap_up();
   end
   initial begin
      repeat (40000) @(posedge i_clk);
      err_total++;
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
